// ---- core/lan_glue_top.sv ----
// Host bus to LAN controller glue: decode, strobes, ready, SRAM control
//
// How it works
// - Read strobe for valid reads of boot ROM, node ID ROM or controller.
// - Write strobe only for valid I/O writes to the controller.
// - Reset out on bus reset or on writes to offsets 0x18-0x1F.
// - Fast/wide output: zero wait in 8-bit modes, 16-bit size in wide.
// - Low transceiver drives host on reads, local side on controller writes.
// - Wide modes enable external upper-byte transceiver; board sets direction.
// - Host interrupt follows either controller interrupt input.
// - Split family uses both interrupts; single family only one.
// - Wait released only after controller done; copies may be tied.
// - Low four address bits latched to controller, remapped per offset.
// - op_config selects family and width of operation.
// - Boot code n places 16 KB window at 0xC4000+n*0x4000; 7 disables.
// - io_base_cfg picks one of eight 32-byte I/O block bases.
// - Offsets 0x00-0x0F select registers, nibble passes unchanged.
// - Single family: 0x10-0x17 select registers with 8,9,A,B,8,9,8,9.
// - Split family: 0x10-0x17 select data port with width remap.
// - Offsets 0x18-0x1F select node ID ROM, nibble 8 through F.
// - Narrow split mode latches buffer address on row strobe 0.
// - Wide split mode drives external row address latch strobe.
// - Wide split mode makes byte write enables from column and write.
// - Wide split mode merges both row strobes onto one output.
// - Wide mode passes high byte enable, held while done is low.
// - Boot select only while access lies in the chosen window.
// - Wait pulled low at decoded controller I/O start, released on done.
// - Strobes assert on bus clock rise, negate at host strobe end.
`timescale 1ns/10ps
module lan_glue_top (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_bus_clk,
	input wire logic [19:0] i_host_addr,
	input wire logic i_aen,
	input wire logic i_ior_n,
	input wire logic i_iow_n,
	input wire logic i_smemr_n,
	input wire logic i_dmack_n,
	input wire logic i_bus_reset_in,
	input wire logic [1:0] i_op_config,
	input wire logic [2:0] i_boot_base_cfg,
	input wire logic [2:0] i_io_base_cfg,
	input wire logic i_rx_irq_in_n,
	input wire logic i_tx_or_any_irq_in_n,
	input wire logic i_ctrl_done_n,
	input wire logic [6:0] i_buf_addr_mux,
	input wire logic i_row_strobe0_n,
	input wire logic [7:0] i_host_data_lo,
	output logic [7:0] o_host_data_lo,
	output logic o_host_data_lo_oe,
	input wire logic [7:0] i_local_data,
	output logic [7:0] o_local_data,
	output logic o_local_data_oe,
	output logic o_ctrl_rd_strobe_n,
	output logic o_ctrl_wr_strobe_n,
	output logic o_ctrl_reset,
	output logic o_fast_or_wide_n,
	output logic o_fast_or_wide_n_oe,
	output logic o_bus_wait_release,
	output logic o_bus_wait_release_oe,
	output logic o_irq_req,
	output logic o_irq_req_oe,
	output logic [3:0] o_ctrl_addr_lo,
	output logic o_reg_or_chip_sel_n,
	output logic o_data_port_sel_n,
	output logic o_boot_mem_sel_n,
	output logic o_node_id_mem_sel_n,
	output logic o_hi_xcvr_oe_n,
	output logic [6:0] o_buf_addr_held,
	output logic o_row_latch_stb,
	output logic o_sram_wr_lo_n,
	output logic o_sram_wr_hi_n,
	output logic o_ctrl_hi_byte_en_n,
	output logic o_any_row_strobe_n
);
	import lan_glue_pkg::*;
	typedef enum logic [1:0] {
		CYC_IDLE = 2'b00, CYC_WAIT = 2'b01, CYC_DONE = 2'b11
	} cycle_e;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisation
	localparam int SYNC_W = 62;
	// Synchroniser resets to each pin's idle level, so release shows no
	// false strobe or interrupt; bus reset reads asserted until synced
	localparam logic [SYNC_W-1:0] SYNC_IDLE = {20'h00000, 5'h1F, 1'b1,
		1'b0, 3'h7, 7'h7F, 1'b1, 8'h00, 8'h00, 2'h0, 3'h0, 3'h0};
	logic [SYNC_W-1:0] raw_pins, sync_pins;
	logic [19:0] addr_s;
	logic aen_s, ior_n_s, iow_n_s, smemr_n_s, dmack_n_s, bus_reset_s;
	logic bus_clk_s, rx_irq_n_s, tx_irq_n_s, done_n_s, row_strobe0_n_n_s;
	logic [6:0] ba_s;
	logic [7:0] host_data_s, local_data_s;
	logic [1:0] mode_s;
	logic [2:0] boot_cfg_s, io_cfg_s;

	assign raw_pins = {i_host_addr, i_aen, i_ior_n, i_iow_n, i_smemr_n,
		i_dmack_n, i_bus_reset_in, i_bus_clk, i_rx_irq_in_n,
		i_tx_or_any_irq_in_n, i_ctrl_done_n, i_buf_addr_mux,
		i_row_strobe0_n, i_host_data_lo, i_local_data, i_op_config,
		i_boot_base_cfg, i_io_base_cfg};

	sync2 #(
		.WIDTH(SYNC_W),
		.RESET_VAL(SYNC_IDLE)
	) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_async(raw_pins),
		.o_sync(sync_pins)
	);

	assign {addr_s, aen_s, ior_n_s, iow_n_s, smemr_n_s, dmack_n_s,
		bus_reset_s, bus_clk_s, rx_irq_n_s, tx_irq_n_s, done_n_s, ba_s,
		row_strobe0_n_n_s, host_data_s, local_data_s, mode_s, boot_cfg_s,
		io_cfg_s} = sync_pins;

	////////////////////////////////////////////////////////////////////
	// Address decode
	logic wide_mode, split_mode, io_hit, io_rd, io_wr, to_ctrl;
	logic boot_hit, boot_rd;
	logic [5:0] boot_page;
	sel_kind_e map_sel;
	logic [3:0] map_addr_lo;

	assign wide_mode = mode_s[MODE_WIDE_BIT];
	assign split_mode = mode_s[MODE_SPLIT_BIT];

	assign io_hit = !aen_s && dmack_n_s &&
		(addr_s[IO_BLOCK_MSB:IO_BLOCK_LSB] == io_block_base(io_cfg_s));
	assign io_rd = io_hit && !ior_n_s;
	assign io_wr = io_hit && !iow_n_s;
	assign to_ctrl = (addr_s[4:0] < OFF_NODE_ID);

	assign boot_page = BOOT_FIRST_PAGE + {3'h0, boot_cfg_s};
	assign boot_hit = (boot_cfg_s != BOOT_CFG_OFF) &&
		(addr_s[19:BOOT_PAGE_LSB] == boot_page);
	assign boot_rd = boot_hit && !smemr_n_s;

	offset_mapper u_map (
		.i_mode(mode_s),
		.i_offset(addr_s[4:0]),
		.o_sel(map_sel),
		.o_addr_lo(map_addr_lo)
	);
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ctrl_addr_lo <= 4'h0;
		end else if (io_hit) begin
			o_ctrl_addr_lo <= map_addr_lo;
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_reg_or_chip_sel_n <= 1'b1;
			o_data_port_sel_n <= 1'b1;
			o_node_id_mem_sel_n <= 1'b1;
			o_boot_mem_sel_n <= 1'b1;
		end else begin
			o_reg_or_chip_sel_n <= !((io_rd || io_wr) && map_sel == SEL_REG);
			o_data_port_sel_n <= !((io_rd || io_wr) && map_sel == SEL_DATA);
			o_node_id_mem_sel_n <=
				!((io_rd || io_wr) && map_sel == SEL_NODE_ID);
			o_boot_mem_sel_n <= !boot_rd;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Strobes and reset
	logic bus_clk_d_q, bus_clk_rise, rd_want, wr_want;
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bus_clk_d_q <= 1'b0;
		end else begin
			bus_clk_d_q <= bus_clk_s;
		end
	end
	assign bus_clk_rise = bus_clk_s && !bus_clk_d_q;
	assign rd_want = io_rd || boot_rd;
	assign wr_want = io_wr && to_ctrl;
	// assert on bus clock rise, drop with host strobe
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ctrl_rd_strobe_n <= 1'b1;
			o_ctrl_wr_strobe_n <= 1'b1;
		end else begin
			if (!rd_want) begin
				o_ctrl_rd_strobe_n <= 1'b1;
			end else if (bus_clk_rise) begin
				o_ctrl_rd_strobe_n <= 1'b0;
			end
			if (!wr_want) begin
				o_ctrl_wr_strobe_n <= 1'b1;
			end else if (bus_clk_rise) begin
				o_ctrl_wr_strobe_n <= 1'b0;
			end
		end
	end
	// bus reset or node ID write
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ctrl_reset <= 1'b1;
		end else begin
			o_ctrl_reset <= bus_reset_s || (io_wr && !to_ctrl);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Cycle tracking and ready
	cycle_e cyc_q;
	logic strobe_any;
	assign strobe_any = io_rd || io_wr;

	// wait from decoded controller start until done
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cyc_q <= CYC_IDLE;
		end else begin
			unique case (cyc_q)
				CYC_IDLE: begin
					// Node ID ROM has no done handshake, so skip waiting
					if (strobe_any) begin
						cyc_q <= to_ctrl ? CYC_WAIT : CYC_DONE;
					end
				end
				CYC_WAIT: begin
					if (!strobe_any) begin
						cyc_q <= CYC_IDLE;
					end else if (!done_n_s) begin
						cyc_q <= CYC_DONE;
					end
				end
				CYC_DONE: begin
					if (!strobe_any) begin
						cyc_q <= CYC_IDLE;
					end
				end
				default: begin
					cyc_q <= CYC_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_bus_wait_release <= 1'b1;
			o_bus_wait_release_oe <= 1'b0;
		end else begin
			o_bus_wait_release <= 1'b0;
			o_bus_wait_release_oe <= strobe_any && to_ctrl &&
				(cyc_q != CYC_DONE) && done_n_s;
		end
	end
	// zero wait when narrow, channel size when wide
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_fast_or_wide_n <= 1'b1;
			o_fast_or_wide_n_oe <= 1'b0;
		end else begin
			o_fast_or_wide_n <= 1'b0;
			if (wide_mode) begin
				o_fast_or_wide_n_oe <= io_hit;
			end else if (!strobe_any) begin
				o_fast_or_wide_n_oe <= 1'b0;
			end else if (bus_clk_rise && cyc_q == CYC_DONE) begin
				o_fast_or_wide_n_oe <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Data transceivers and interrupt
	// direction from host strobes
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_host_data_lo <= 8'h00;
			o_host_data_lo_oe <= 1'b0;
			o_local_data <= 8'h00;
			o_local_data_oe <= 1'b0;
		end else begin
			o_host_data_lo <= local_data_s;
			o_host_data_lo_oe <= rd_want;
			o_local_data <= host_data_s;
			o_local_data_oe <= wr_want;
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_hi_xcvr_oe_n <= 1'b1;
		end else begin
			o_hi_xcvr_oe_n <= !(wide_mode && strobe_any && to_ctrl);
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_irq_req <= 1'b0;
			o_irq_req_oe <= 1'b0;
		end else begin
			o_irq_req <= !tx_irq_n_s || (split_mode && !rx_irq_n_s);
			o_irq_req_oe <= !tx_irq_n_s || (split_mode && !rx_irq_n_s);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Buffer SRAM control
	logic row_strobe0_n_d_q, row_any_low;
	assign row_any_low = !row_strobe0_n_n_s || !ba_s[BA_ROW1];
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			row_strobe0_n_d_q <= 1'b1;
		end else begin
			row_strobe0_n_d_q <= row_strobe0_n_n_s;
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_buf_addr_held <= 7'h00;
		end else if (mode_s == MODE_SPLIT_8 && row_strobe0_n_d_q && !row_strobe0_n_n_s) begin
			o_buf_addr_held <= ba_s;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_row_latch_stb <= 1'b0;
			o_sram_wr_lo_n <= 1'b1;
			o_sram_wr_hi_n <= 1'b1;
			o_any_row_strobe_n <= 1'b1;
		end else begin
			o_row_latch_stb <= (mode_s == MODE_SPLIT_16) && row_any_low;
			o_sram_wr_lo_n <= !(mode_s == MODE_SPLIT_16 &&
				!ba_s[BA_COL] && !ba_s[BA_WR_EN]);
			o_sram_wr_hi_n <= !(mode_s == MODE_SPLIT_16 &&
				!ba_s[BA_COL] && !ba_s[BA_WR_EN]);
			o_any_row_strobe_n <= !(mode_s == MODE_SPLIT_16 && row_any_low);
		end
	end

	// high byte enable held while done low
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ctrl_hi_byte_en_n <= 1'b1;
		end else if (!wide_mode) begin
			o_ctrl_hi_byte_en_n <= 1'b1;
		end else if (done_n_s) begin
			o_ctrl_hi_byte_en_n <= ba_s[BA_HI_BYTE];
		end
	end
endmodule

// ---- core/offset_mapper.sv ----
// Maps an I/O block offset and mode to a select class and low nibble
`timescale 1ns/10ps
module offset_mapper (
	input wire logic [1:0] i_mode,
	input wire logic [4:0] i_offset,
	output lan_glue_pkg::sel_kind_e o_sel,
	output logic [3:0] o_addr_lo
);
	import lan_glue_pkg::*;

	logic [2:0] sub;

	always_comb begin
		sub = i_offset[2:0];
		o_sel = SEL_REG;
		o_addr_lo = i_offset[3:0];
		if (i_offset >= OFF_NODE_ID) begin
			o_sel = SEL_NODE_ID;
			o_addr_lo = {1'b1, sub};
		end else if (i_offset >= OFF_DATA_PORT) begin
			unique case (i_mode)
				MODE_SINGLE_8, MODE_SINGLE_16: begin
					o_sel = SEL_REG;
					o_addr_lo = (sub[2:1] == 2'h1) ?
						{3'h5, sub[0]} : {3'h4, sub[0]};
				end
				MODE_SPLIT_8: begin
					o_sel = SEL_DATA;
					o_addr_lo = (sub == 3'h1) ? 4'h0 : {1'b0, sub};
				end
				MODE_SPLIT_16: begin
					o_sel = SEL_DATA;
					o_addr_lo = (sub[2:1] == 2'h1) ?
						{1'b0, sub} : {3'h0, sub[0]};
				end
			endcase
		end
	end
endmodule

// ---- core/sync2.sv ----
// Two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/10ps
module sync2 #(
	parameter int WIDTH = 1,
	// Idle level of each pin, so reset release makes no false edge
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_q <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// ---- inc/lan_glue_pkg.sv ----
// Shared constants for the host bus to LAN controller glue block
package lan_glue_pkg;

	// Operating modes, op_config[1] selects family, op_config[0] width
	localparam logic [1:0] MODE_SINGLE_8 = 2'h0;
	localparam logic [1:0] MODE_SINGLE_16 = 2'h1;
	localparam logic [1:0] MODE_SPLIT_8 = 2'h2;
	localparam logic [1:0] MODE_SPLIT_16 = 2'h3;
	localparam int MODE_WIDE_BIT = 0;
	localparam int MODE_SPLIT_BIT = 1;

	// Block offsets inside the 32-byte I/O window
	localparam logic [4:0] OFF_DATA_PORT = 5'h10;
	localparam logic [4:0] OFF_NODE_ID = 5'h18;
	localparam int IO_BLOCK_LSB = 5;
	localparam int IO_BLOCK_MSB = 9;

	// Boot ROM: 16 KB windows from 0xC4000, code 7 turns decoding off
	localparam int BOOT_PAGE_LSB = 14;
	localparam logic [5:0] BOOT_FIRST_PAGE = 6'h31;
	localparam logic [2:0] BOOT_CFG_OFF = 3'h7;

	// Buffer address bus pins that double as strobes in wide split mode
	localparam int BA_ROW1 = 0;
	localparam int BA_COL = 1;
	localparam int BA_WR_EN = 2;
	localparam int BA_HI_BYTE = 3;

	// Select classes produced by the offset mapper
	typedef enum logic [1:0] {
		SEL_REG = 2'h0,
		SEL_DATA = 2'h1,
		SEL_NODE_ID = 2'h3
	} sel_kind_e;

	// I/O block base, address bits 9:5, per io_base_cfg code
	function automatic logic [4:0] io_block_base(input logic [2:0] cfg);
		logic [4:0] base;
		base = 5'h13;
		unique case (cfg)
			3'h0: base = 5'h13;
			3'h1: base = 5'h14;
			3'h2: base = 5'h15;
			3'h3: base = 5'h17;
			3'h4: base = 5'h18;
			3'h5: base = 5'h19;
			3'h6: base = 5'h1C;
			3'h7: base = 5'h1F;
		endcase
		return base;
	endfunction

endpackage

// ---- verification/lan_ctrl_model.sv ----
// Behavioural LAN controller: ready handshake and read data
`timescale 1ns/10ps
module lan_ctrl_model (
	input wire logic i_sys_clk,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [3:0] i_delay,
	output logic o_done_n,
	output logic [7:0] o_data
);
	logic [3:0] cnt = 4'h0;
	logic [7:0] pat = 8'h3C;
	initial o_done_n = 1'h1;
	always @(posedge i_sys_clk) begin
		pat <= ~pat;
		if (i_rd_n && i_wr_n) begin
			cnt <= 4'h0;
			o_done_n <= 1'h1;
		end else if (cnt == i_delay) begin
			o_done_n <= 1'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	// Released bus toggles so a stale byte never passes
	assign o_data = i_rd_n ? pat : 8'hC3;
endmodule

// ---- verification/lan_glue_chk.sv ----
// Concurrent checks on the glue block's pins
`timescale 1ns/10ps
module lan_glue_chk (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [1:0] i_op_config,
	input wire logic [2:0] i_boot_base_cfg,
	input wire logic i_aen,
	input wire logic i_ior_n,
	input wire logic i_bus_reset_in,
	input wire logic i_tx_or_any_irq_in_n,
	input wire logic i_ctrl_done_n,
	input wire logic i_row_strobe0_n,
	input wire logic o_ctrl_wr_strobe_n,
	input wire logic o_ctrl_reset,
	input wire logic o_fast_or_wide_n_oe,
	input wire logic o_bus_wait_release_oe,
	input wire logic o_irq_req_oe,
	input wire logic o_reg_or_chip_sel_n,
	input wire logic o_data_port_sel_n,
	input wire logic o_boot_mem_sel_n,
	input wire logic o_node_id_mem_sel_n,
	input wire logic o_row_latch_stb,
	input wire logic o_any_row_strobe_n
);
	import lan_glue_pkg::*;
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);
	logic wide_split;
	assign wide_split = i_op_config == MODE_SPLIT_16;
	////////////////////////////////////////////////////////////////////////
	a_reset_follow: assert property (
		$rose(i_bus_reset_in) |-> ##[1:4] o_ctrl_reset)
		else $error("reset out missed bus reset");
	a_irq_follow: assert property (
		$fell(i_tx_or_any_irq_in_n) |-> ##[1:4] o_irq_req_oe)
		else $error("interrupt not forwarded");
	a_aen_blocks: assert property (
		i_aen [*4] |-> o_reg_or_chip_sel_n && o_data_port_sel_n &&
		o_node_id_mem_sel_n)
		else $error("select while address enable high");
	a_wait_hold: assert property (
		(i_ctrl_done_n && !i_ior_n) [*4] ##0 o_bus_wait_release_oe
		|=> o_bus_wait_release_oe)
		else $error("wait released before done");
	a_wait_free: assert property (
		$fell(i_ctrl_done_n) |-> ##[1:5] !o_bus_wait_release_oe)
		else $error("wait held after done");
	a_one_select: assert property (
		$onehot0({!o_reg_or_chip_sel_n, !o_data_port_sel_n,
		!o_node_id_mem_sel_n, !o_boot_mem_sel_n}))
		else $error("two selects at once");
	a_nid_no_write: assert property (
		!o_node_id_mem_sel_n |-> o_ctrl_wr_strobe_n &&
		!o_bus_wait_release_oe)
		else $error("node id access wrote or waited");
	a_boot_off: assert property (
		!o_boot_mem_sel_n |-> i_boot_base_cfg != BOOT_CFG_OFF &&
		o_ctrl_wr_strobe_n)
		else $error("boot select while disabled");
	a_zws_late: assert property (
		o_fast_or_wide_n_oe && !i_op_config[0] |-> !o_bus_wait_release_oe)
		else $error("zero wait before ready");
	a_row_merge: assert property (
		(wide_split && !i_row_strobe0_n) [*4] |-> !o_any_row_strobe_n &&
		o_row_latch_stb)
		else $error("row strobe not merged");
	c_boot: cover property (!o_boot_mem_sel_n);
	c_write: cover property ($fell(o_ctrl_wr_strobe_n));
	c_irq: cover property (o_irq_req_oe);
endmodule

bind lan_glue_top lan_glue_chk u_chk (.i_sys_clk, .i_rstn, .i_op_config,
	.i_boot_base_cfg, .i_aen, .i_ior_n, .i_bus_reset_in,
	.i_tx_or_any_irq_in_n, .i_ctrl_done_n, .i_row_strobe0_n,
	.o_ctrl_wr_strobe_n, .o_ctrl_reset, .o_fast_or_wide_n_oe,
	.o_bus_wait_release_oe, .o_irq_req_oe, .o_reg_or_chip_sel_n,
	.o_data_port_sel_n, .o_boot_mem_sel_n, .o_node_id_mem_sel_n,
	.o_row_latch_stb, .o_any_row_strobe_n);

// ---- verification/tb.sv ----
// Self-checking bench for the host bus to LAN glue block
`timescale 1ns/10ps
module tb;
	import lan_glue_pkg::*;
	logic i_sys_clk = 1'h0, i_rstn = 1'h0, i_bus_clk = 1'h0;
	logic [19:0] i_host_addr = 20'h0;
	logic i_aen = 1'h1, i_ior_n = 1'h1, i_iow_n = 1'h1, i_smemr_n = 1'h1;
	logic i_dmack_n = 1'h1, i_bus_reset_in = 1'h1, i_row_strobe0_n = 1'h1;
	logic i_rx_irq_in_n = 1'h1, i_tx_or_any_irq_in_n = 1'h1, i_ctrl_done_n;
	logic [1:0] i_op_config = 2'h0;
	logic [2:0] i_boot_base_cfg = 3'h7, i_io_base_cfg = 3'h0;
	logic [6:0] i_buf_addr_mux = 7'h7F, o_buf_addr_held;
	logic [7:0] i_host_data_lo = 8'h69, i_local_data;
	logic [7:0] o_host_data_lo, o_local_data;
	logic [3:0] o_ctrl_addr_lo, dly = 4'h0;
	logic o_host_data_lo_oe, o_local_data_oe, o_ctrl_rd_strobe_n;
	logic o_ctrl_wr_strobe_n, o_ctrl_reset, o_fast_or_wide_n;
	logic o_fast_or_wide_n_oe, o_bus_wait_release, o_bus_wait_release_oe;
	logic o_irq_req, o_irq_req_oe, o_reg_or_chip_sel_n, o_data_port_sel_n;
	logic o_boot_mem_sel_n, o_node_id_mem_sel_n, o_hi_xcvr_oe_n;
	logic o_row_latch_stb, o_sram_wr_lo_n, o_sram_wr_hi_n;
	logic o_ctrl_hi_byte_en_n, o_any_row_strobe_n;
	logic [9:0] base [8] = '{10'h260, 10'h280, 10'h2A0, 10'h2E0, 10'h300,
		10'h320, 10'h380, 10'h3E0};
	int fails = 0, n_tests = 0, cyc = 0;

	lan_glue_top DUT (.i_sys_clk, .i_rstn, .i_bus_clk, .i_host_addr, .i_aen,
		.i_ior_n, .i_iow_n, .i_smemr_n, .i_dmack_n, .i_bus_reset_in,
		.i_op_config, .i_boot_base_cfg, .i_io_base_cfg, .i_rx_irq_in_n,
		.i_tx_or_any_irq_in_n, .i_ctrl_done_n, .i_buf_addr_mux,
		.i_row_strobe0_n, .i_host_data_lo, .o_host_data_lo,
		.o_host_data_lo_oe, .i_local_data, .o_local_data, .o_local_data_oe,
		.o_ctrl_rd_strobe_n, .o_ctrl_wr_strobe_n, .o_ctrl_reset,
		.o_fast_or_wide_n, .o_fast_or_wide_n_oe, .o_bus_wait_release,
		.o_bus_wait_release_oe, .o_irq_req, .o_irq_req_oe, .o_ctrl_addr_lo,
		.o_reg_or_chip_sel_n, .o_data_port_sel_n, .o_boot_mem_sel_n,
		.o_node_id_mem_sel_n, .o_hi_xcvr_oe_n, .o_buf_addr_held,
		.o_row_latch_stb, .o_sram_wr_lo_n, .o_sram_wr_hi_n,
		.o_ctrl_hi_byte_en_n, .o_any_row_strobe_n);
	lan_ctrl_model PEER (.i_sys_clk, .i_rd_n(o_ctrl_rd_strobe_n),
		.i_wr_n(o_ctrl_wr_strobe_n), .i_delay(dly),
		.o_done_n(i_ctrl_done_n), .o_data(i_local_data));

	initial forever #2 i_sys_clk = ~i_sys_clk;
	// Bus clock runs free at 1/16 the system clock rate, its edges on system clock falls
	initial forever #32 i_bus_clk = ~i_bus_clk;
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t got %0h exp %0h", $time, g, e);
		end
	endtask
	task automatic chk_b(input logic g, input logic e);
		chk_v({7'h0, g}, {7'h0, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask
	function automatic logic [3:0] nib(input logic [4:0] o);
		if (!o[4] || o[3])
			return o[3:0];
		if (!i_op_config[1])
			return {2'h2, o[1] & !o[2], o[0]};
		if (!i_op_config[0])
			return {1'h0, o[2:1], o[0] & |o[2:1]};
		return {2'h0, o[1] & !o[2], o[0]};
	endfunction
	task automatic io(input logic wr, input logic [9:0] a, input logic ae,
		input logic hit);
		logic nid, ctl, sp;
		nid = hit && a[4:3] == 2'h3;
		ctl = hit && !nid;
		sp = i_op_config[1];
		i_host_addr = {10'h0, a};
		i_aen = ae;
		i_iow_n = !wr;
		i_ior_n = wr;
		i_host_data_lo = wr ? 8'h96 : 8'h69;
		tick(5);
		chk_b(o_bus_wait_release_oe, ctl);
		tick(50);
		chk_b(o_reg_or_chip_sel_n, !(ctl && !(sp && a[4])));
		chk_b(o_data_port_sel_n, !(ctl && sp && a[4]));
		chk_b(o_node_id_mem_sel_n, !nid);
		if (hit) chk_v({4'h0, o_ctrl_addr_lo}, {4'h0, nib(a[4:0])});
		chk_b(o_ctrl_rd_strobe_n, !(hit && !wr));
		chk_b(o_ctrl_wr_strobe_n, !(ctl && wr));
		chk_b(o_ctrl_reset, nid && wr);
		chk_b(o_host_data_lo_oe, hit && !wr);
		chk_b(o_local_data_oe, ctl && wr);
		if (hit && !wr) chk_v(o_host_data_lo, 8'hC3);
		if (ctl && wr) chk_v(o_local_data, 8'h96);
		chk_b(o_bus_wait_release_oe, 1'h0);
		if (!nid) chk_b(o_fast_or_wide_n_oe, ctl);
		if (!nid) chk_b(o_hi_xcvr_oe_n, !(ctl && i_op_config[0]));
		i_ior_n = 1'h1;
		i_iow_n = 1'h1;
		i_aen = 1'h1;
		tick(8);
		chk_b(o_ctrl_rd_strobe_n & o_ctrl_wr_strobe_n, 1'h1);
		chk_b(o_host_data_lo_oe | o_local_data_oe, 1'h0);
	endtask
	task automatic mem(input logic [19:0] a, input logic hit);
		i_host_addr = a;
		i_smemr_n = 1'h0;
		tick(30);
		chk_b(o_boot_mem_sel_n, !hit);
		chk_b(o_ctrl_rd_strobe_n, !hit);
		chk_b(o_host_data_lo_oe, hit);
		i_smemr_n = 1'h1;
		tick(8);
		chk_b(o_boot_mem_sel_n, 1'h1);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		tick(6);
		i_rstn = 1'h1;
		tick(6);
		chk_b(o_ctrl_reset, 1'h1);
		i_bus_reset_in = 1'h0;
		tick(6);
		chk_b(o_ctrl_reset, 1'h0);
		for (int m = 0; m < 4; m++) begin
			i_op_config = m[1:0];
			dly = {m[1:0], 2'h0};
			tick(4);
			for (int o = 0; o < 32; o++)
				io(1'h0, 10'h260 + 10'(o), 1'h0, 1'h1);
			for (int o = 0; o < 32; o += 7)
				io(1'h1, 10'h260 + 10'(o), 1'h0, 1'h1);
		end
		for (int c = 0; c < 8; c++) begin
			i_io_base_cfg = c[2:0];
			i_boot_base_cfg = c[2:0];
			io(1'h0, base[c] + 10'h1, 1'h0, 1'h1);
			io(1'h0, base[c] + 10'h20, 1'h0, 1'h0);
			io(1'h0, base[c] + 10'h1, 1'h1, 1'h0);
			mem(20'hC4000 + {c[2:0], 14'h0}, c < 7);
			mem(20'hC7FFF + {c[2:0], 14'h0}, c < 7);
		end
		i_boot_base_cfg = 3'h0;
		mem(20'hC3FFF, 1'h0);
		mem(20'hC8000, 1'h0);
		for (int m = 0; m < 4; m += 2) begin
			i_op_config = m[1:0];
			i_rx_irq_in_n = 1'h0;
			tick(6);
			chk_b(o_irq_req_oe, m[1]);
			i_rx_irq_in_n = 1'h1;
			i_tx_or_any_irq_in_n = 1'h0;
			tick(6);
			chk_b(o_irq_req_oe & o_irq_req, 1'h1);
			i_tx_or_any_irq_in_n = 1'h1;
			tick(6);
			chk_b(o_irq_req_oe, 1'h0);
		end
		i_buf_addr_mux = 7'h55;
		tick(2);
		i_row_strobe0_n = 1'h0;
		tick(6);
		i_buf_addr_mux = 7'h2A;
		tick(6);
		chk_v({1'h0, o_buf_addr_held}, 8'h55);
		i_row_strobe0_n = 1'h1;
		tick(2);
		i_row_strobe0_n = 1'h0;
		tick(6);
		chk_v({1'h0, o_buf_addr_held}, 8'h2A);
		i_row_strobe0_n = 1'h1;
		i_buf_addr_mux = 7'h71;
		tick(6);
		chk_b(o_ctrl_hi_byte_en_n, 1'h1);
		i_op_config = MODE_SPLIT_16;
		i_buf_addr_mux = 7'h7F;
		tick(6);
		chk_b(o_any_row_strobe_n & !o_row_latch_stb, 1'h1);
		i_row_strobe0_n = 1'h0;
		tick(6);
		chk_b(o_any_row_strobe_n | !o_row_latch_stb, 1'h0);
		i_row_strobe0_n = 1'h1;
		i_buf_addr_mux = 7'h7E;
		tick(6);
		chk_b(o_any_row_strobe_n, 1'h0);
		chk_b(o_sram_wr_lo_n & o_sram_wr_hi_n, 1'h1);
		i_buf_addr_mux = 7'h75;
		tick(6);
		chk_b(o_sram_wr_lo_n & o_sram_wr_hi_n, 1'h1);
		i_buf_addr_mux = 7'h71;
		tick(6);
		chk_b(o_sram_wr_lo_n | o_sram_wr_hi_n, 1'h0);
		chk_b(o_ctrl_hi_byte_en_n, 1'h0);
		chk_b(o_any_row_strobe_n, 1'h1);
		i_rstn = 1'h0;
		tick(2);
		i_rstn = 1'h1;
		tick(2);
		chk_b(o_irq_req_oe | !o_ctrl_reset, 1'h0);
		i_bus_reset_in = 1'h1;
		tick(6);
		chk_b(o_ctrl_reset, 1'h1);
		i_bus_reset_in = 1'h0;
		tick(6);
		chk_b(o_ctrl_reset, 1'h0);
		summarize();
	end
endmodule
